/* File: nandcb_pkg.sv */
// Behaviour
// - copy-back is read-for-copy then program-for-copy, both in one plane.
// - read-for-copy is 00h, five source address cycles, then 35h.
// - copy program is 85h, five destination cycles, 10h; busy meanwhile.
// - 85h random data input may repeat before 10h to patch cache bytes.
// - erase is 60h, three block address cycles, D0h; busy for erase time.
// - queued erase is 60h, three row cycles, D1h; busy for dummy time.
// - once status bits 6 and 5 are one, queue more or confirm D0h.
// - plane bit low in first address set, high in second.
// - both planes of a two-plane operation use the same operation type.
// - software should check copied data with ECC before programming.
// - between dummy busy and next setup only 70h, 78h or FFh.
`default_nettype none
package nandcb_pkg;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_NS = 100;
   localparam int T_WB_NS = 100;
   localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_CYC = 3;
   localparam logic [2:0] WAIT_CNT = 3'(WB_CYC + SYNC_CYC);
   localparam logic [2:0] RD_CNT = 3'(SYNC_CYC);
   // ************************************************************
   // register map and fields
   // ************************************************************
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_COL = 8'h04;
   localparam logic [7:0] A_ROW = 8'h08;
   localparam logic [7:0] A_WDAT = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_CFG = 8'h14;
   localparam int PLANE_BIT = 6;
   localparam int ST_BIT_RDY = 6;
   localparam int ST_BIT_ARDY = 5;
   localparam logic WP_RST = 1'b0;
   // ************************************************************
   // flash commands
   // ************************************************************
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_CB_CONF = 8'h35;
   localparam logic [7:0] CMD_RAND_IN = 8'h85;
   localparam logic [7:0] CMD_PROG_CONF = 8'h10;
   localparam logic [7:0] CMD_ROUT = 8'h05;
   localparam logic [7:0] CMD_ROUT_CONF = 8'hE0;
   localparam logic [7:0] CMD_ERASE = 8'h60;
   localparam logic [7:0] CMD_ERASE_CONF = 8'hD0;
   localparam logic [7:0] CMD_QUEUE_CONF = 8'hD1;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_STAT_ENH = 8'h78;
   // ************************************************************
   // operations and states
   // ************************************************************
   typedef enum logic [3:0] {
      OP_CB_READ = 4'h0, OP_CB_PROG = 4'h1, OP_RAND_IN = 4'h2,
      OP_RAND_OUT = 4'h3, OP_READ = 4'h4, OP_ERASE = 4'h5,
      OP_ERASE_Q = 4'h6, OP_RESET = 4'h7, OP_STATUS = 4'h8,
      OP_STAT_ENH = 4'h9
   } nandcb_op_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_CMD1 = 3'b001, ST_ADDR = 3'b010,
      ST_DATA = 3'b011, ST_CMD2 = 3'b100, ST_WAIT = 3'b101,
      ST_SCMD = 3'b110, ST_READ = 3'b111
   } nandcb_state_t;
endpackage : nandcb_pkg
`default_nettype wire

/* File: nandcb_host.sv */
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module nandcb_host import nandcb_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic nand_ce_n,
   output logic nand_cle,
   output logic nand_ale,
   output logic nand_we_n,
   output logic read_strobe_n,
   output logic nand_wp_n,
   output logic [7:0] nand_io_o,
   output logic nand_io_oe,
   input wire logic [7:0] nand_io_i,
   input wire logic ready_busy_n
);
   // ************************************************************
   // state
   // ************************************************************
   nandcb_state_t state, next_state;
   nandcb_op_t op, next_op, nop;
   logic [1:0] ph, next_ph;
   logic [2:0] idx, next_idx, cnt, next_cnt, na, sel3;
   logic [15:0] col, next_col, acol, next_acol;
   logic [23:0] row, next_row, arow, next_arow;
   logic [7:0] wdat, next_wdat, rd_byte, next_rd, stat_byte, next_stat;
   logic [7:0] c1, c2, wbyte, next_io;
   logic [31:0] next_dat, wm;
   logic [39:0] abytes;
   logic next_ack, next_wp, next_ce_n, next_cle, next_ale, next_we_n;
   logic next_re_n, next_oe, cb_ok, next_cb, q_pend, next_q, err;
   logic next_err, src_plane, next_src, sflag, next_sflag;
   logic wr, go, acc, adv, do_data, do_wait, do_stat, do_read;
   logic rb1, rb2, rb3, rb_lvl;
   logic [7:0] io1, io2, io3;
   logic [2:0] acnt;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // level only moves once the last two stages agree
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         {rb1, rb2, rb3, rb_lvl} <= 4'h0;
         io1 <= 8'h00;
         io2 <= 8'h00;
         io3 <= 8'h00;
      end else begin
         rb1 <= ready_busy_n;
         rb2 <= rb1;
         rb3 <= rb2;
         if (rb2 == rb3) rb_lvl <= rb3;
         io1 <= nand_io_i;
         io2 <= io1;
         io3 <= io2;
      end
   end

   // ************************************************************
   // wishbone slave
   // ************************************************************
   // one wait state; writes land on the edge that sees ack high
   always_comb begin
      wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
            {8{wb_sel_i[0]}}};
      wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
      go = wr && (wb_adr_i == A_CTRL) && wb_sel_i[0];
      nop = nandcb_op_t'(wb_dat_i[3:0]);
      next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      next_dat = wb_dat_o;
      next_col = col;
      next_row = row;
      next_wdat = wdat;
      next_wp = nand_wp_n;
      if (next_ack) begin
         case (wb_adr_i)
            A_COL: next_dat = {16'h0000, col};
            A_ROW: next_dat = {8'h00, row};
            A_WDAT: next_dat = {24'h000000, wdat};
            // rd_byte is exposed raw so software can run its ECC
            A_STAT: next_dat = {12'h000, q_pend, cb_ok, err,
                                state != ST_IDLE, stat_byte, rd_byte};
            A_CFG: next_dat = {31'h0, nand_wp_n};
            default: next_dat = 32'h00000000;
         endcase
      end
      if (wr) begin
         case (wb_adr_i)
            A_COL: next_col = (col & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
            A_ROW: next_row = (row & ~wm[23:0]) | (wb_dat_i[23:0] & wm[23:0]);
            A_WDAT: if (wb_sel_i[0]) next_wdat = wb_dat_i[7:0];
            A_CFG: if (wb_sel_i[0]) next_wp = wb_dat_i[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         col <= 16'h0000;
         row <= 24'h000000;
         wdat <= 8'h00;
         nand_wp_n <= WP_RST;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
         col <= next_col;
         row <= next_row;
         wdat <= next_wdat;
         nand_wp_n <= next_wp;
      end
   end

   // ************************************************************
   // operation decode
   // ************************************************************
   always_comb begin
      {c1, c2, na} = {CMD_READ, CMD_READ, 3'h0};
      {do_data, do_wait, do_stat, do_read} = 4'h0;
      unique case (op)
         OP_CB_READ: {c1, c2, na, do_wait} = {CMD_READ, CMD_CB_CONF,
                                               3'h5, 1'b1};
         OP_CB_PROG: {c1, c2, na, do_wait, do_stat} = {CMD_RAND_IN,
                        CMD_PROG_CONF, 3'h5, 2'b11};
         OP_RAND_IN: {c1, na, do_data} = {CMD_RAND_IN, 3'h2, 1'b1};
         OP_RAND_OUT: {c1, c2, na, do_read} = {CMD_ROUT, CMD_ROUT_CONF,
                                                3'h2, 1'b1};
         OP_READ: do_read = 1'b1;
         OP_ERASE: {c1, c2, na, do_wait, do_stat} = {CMD_ERASE,
                      CMD_ERASE_CONF, 3'h3, 2'b11};
         OP_ERASE_Q: {c1, c2, na, do_wait, do_stat} = {CMD_ERASE,
                        CMD_QUEUE_CONF, 3'h3, 2'b11};
         OP_RESET: {c1, do_wait, do_stat} = {CMD_RESET, 2'b11};
         OP_STATUS: {c1, do_read} = {CMD_STATUS, 1'b1};
         OP_STAT_ENH: {c1, na, do_read} = {CMD_STAT_ENH, 3'h3, 1'b1};
      endcase
      // row-only ops skip the two column bytes
      abytes = {arow, acol};
      sel3 = (na == 3'h3) ? idx + 3'h2 : idx;
      if (state == ST_CMD1) wbyte = c1;
      else if (state == ST_CMD2) wbyte = c2;
      else if (state == ST_SCMD) wbyte = CMD_STATUS;
      else if (state == ST_DATA) wbyte = wdat;
      else wbyte = abytes[{sel3, 3'b000} +: 8];
   end

   // ************************************************************
   // acceptance of a new operation
   // ************************************************************
   // a queued erase locks out everything but erase, status and reset
   always_comb begin
      case (nop)
         OP_READ, OP_RAND_OUT, OP_RAND_IN, OP_CB_PROG:
            acc = cb_ok & ~q_pend;
         OP_CB_READ: acc = ~q_pend;
         OP_ERASE, OP_ERASE_Q:
            acc = ~q_pend | (stat_byte[ST_BIT_RDY] &
                             stat_byte[ST_BIT_ARDY]);
         OP_STATUS, OP_STAT_ENH, OP_RESET: acc = 1'b1;
         default: acc = 1'b0;
      endcase
   end

   // ************************************************************
   // flash cycle sequencer
   // ************************************************************
   // each written byte: setup, strobe low, strobe high, hold
   always_comb begin
      next_state = state;
      next_op = op;
      next_ph = ph;
      next_idx = idx;
      next_cnt = cnt;
      next_cle = nand_cle;
      next_ale = nand_ale;
      next_we_n = nand_we_n;
      next_re_n = read_strobe_n;
      next_io = nand_io_o;
      next_oe = nand_io_oe;
      next_rd = rd_byte;
      next_stat = stat_byte;
      next_cb = cb_ok;
      next_q = q_pend;
      next_err = err;
      next_src = src_plane;
      next_arow = arow;
      next_acol = acol;
      next_sflag = sflag;
      next_ce_n = nand_ce_n;
      adv = 1'b0;
      if (state inside {ST_CMD1, ST_ADDR, ST_DATA, ST_CMD2, ST_SCMD}) begin
         unique case (ph)
            2'd0: begin
               next_io = wbyte;
               next_oe = 1'b1;
               next_cle = state inside {ST_CMD1, ST_CMD2, ST_SCMD};
               next_ale = state == ST_ADDR;
               next_ph = 2'd1;
            end
            2'd1: begin
               next_we_n = 1'b0;
               next_ph = 2'd2;
            end
            2'd2: begin
               next_we_n = 1'b1;
               next_ph = 2'd3;
            end
            2'd3: begin
               // latch lines held one cycle past the rising strobe
               {next_cle, next_ale, next_oe} = 3'b000;
               next_ph = 2'd0;
               adv = 1'b1;
            end
         endcase
      end
      unique case (state)
         ST_IDLE: begin
            if (go && !acc) next_err = 1'b1;
            else if (go) begin
               next_op = nop;
               next_err = 1'b0;
               next_ce_n = 1'b0;
               {next_ph, next_idx, next_sflag} = 6'h00;
               next_acol = col;
               next_arow = row;
               next_state = (nop == OP_READ) ? ST_READ : ST_CMD1;
               case (nop)
                  OP_CB_READ: begin
                     next_cb = 1'b1;
                     next_src = row[PLANE_BIT];
                  end
                  OP_CB_PROG: begin
                     next_cb = 1'b0;
                     next_arow[PLANE_BIT] = src_plane;
                  end
                  OP_ERASE_Q: begin
                     {next_q, next_cb} = 2'b10;
                     next_arow[PLANE_BIT] = 1'b0;
                  end
                  OP_ERASE: begin
                     {next_q, next_cb} = 2'b00;
                     if (q_pend) next_arow[PLANE_BIT] = 1'b1;
                  end
                  OP_RESET: {next_q, next_cb} = 2'b00;
                  default: ;
               endcase
            end
         end
         ST_CMD1: if (adv) begin
            if (na != 3'h0) next_state = ST_ADDR;
            else if (do_wait) begin
               next_state = ST_WAIT;
               next_cnt = WAIT_CNT;
            end else next_state = ST_READ;
         end
         ST_ADDR: if (adv) begin
            next_idx = idx + 3'h1;
            if (idx == na - 3'h1) begin
               if (do_data) next_state = ST_DATA;
               else if (c2 != CMD_READ) next_state = ST_CMD2;
               else next_state = ST_READ;
            end
         end
         ST_DATA: if (adv) next_state = ST_IDLE;
         ST_CMD2: if (adv) begin
            next_state = do_wait ? ST_WAIT : ST_READ;
            next_cnt = WAIT_CNT;
         end
         ST_WAIT: begin
            // busy may show late, so give it time to pass the sync
            if (cnt != 3'h0) next_cnt = cnt - 3'h1;
            else if (rb_lvl) next_state = do_stat ? ST_SCMD : ST_IDLE;
         end
         ST_SCMD: if (adv) begin
            next_state = ST_READ;
            next_sflag = 1'b1;
         end
         ST_READ: begin
            unique case (ph)
               2'd0: begin
                  next_re_n = 1'b0;
                  next_cnt = RD_CNT;
                  next_ph = 2'd1;
               end
               2'd1: begin
                  if (cnt != 3'h0) next_cnt = cnt - 3'h1;
                  else if (io2 == io3) begin
                     if (sflag || op inside {OP_STATUS, OP_STAT_ENH})
                        next_stat = io3;
                     else next_rd = io3;
                     next_re_n = 1'b1;
                     next_ph = 2'd2;
                  end
               end
               2'd2: next_ph = 2'd3;
               2'd3: begin
                  next_ph = 2'd0;
                  next_state = ST_IDLE;
               end
            endcase
         end
      endcase
      if (state != ST_IDLE && next_state == ST_IDLE) next_ce_n = 1'b1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         op <= OP_STATUS;
         {ph, idx, cnt} <= 8'h00;
         {nand_cle, nand_ale, nand_io_oe} <= 3'b000;
         {nand_ce_n, nand_we_n, read_strobe_n} <= 3'b111;
         nand_io_o <= 8'h00;
         rd_byte <= 8'h00;
         stat_byte <= 8'h00;
         {cb_ok, q_pend, err, src_plane, sflag} <= 5'h00;
         arow <= 24'h000000;
         acol <= 16'h0000;
      end else begin
         state <= next_state;
         op <= next_op;
         ph <= next_ph;
         idx <= next_idx;
         cnt <= next_cnt;
         nand_cle <= next_cle;
         nand_ale <= next_ale;
         nand_io_oe <= next_oe;
         nand_ce_n <= next_ce_n;
         nand_we_n <= next_we_n;
         read_strobe_n <= next_re_n;
         nand_io_o <= next_io;
         rd_byte <= next_rd;
         stat_byte <= next_stat;
         cb_ok <= next_cb;
         q_pend <= next_q;
         err <= next_err;
         src_plane <= next_src;
         sflag <= next_sflag;
         arow <= next_arow;
         acol <= next_acol;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   // address bytes latched since the last command byte
   always_ff @(posedge ref_clk) begin
      if (!rst_n) acnt <= 3'h0;
      else if (nand_we_n && !$past(nand_we_n)) begin
         if (nand_cle) acnt <= 3'h0;
         else if (nand_ale) acnt <= acnt + 3'h1;
      end
   end

   default clocking cb_clk @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   cb_read_a: assert property ($rose(nand_we_n) && nand_cle &&
      nand_io_o == CMD_CB_CONF |-> acnt == 3'h5 ##1 state == ST_WAIT)
      else $error("copy read confirm without five address bytes");
   cb_prog_a: assert property ($rose(nand_we_n) && nand_cle &&
      nand_io_o == CMD_PROG_CONF |-> acnt == 3'h5)
      else $error("copy program confirm without five address bytes");
   erase_addr_a: assert property ($rose(nand_we_n) && nand_cle &&
      nand_io_o == CMD_ERASE_CONF |-> acnt == 3'h3 ##1 state == ST_WAIT)
      else $error("erase confirm without three address bytes");
   queue_addr_a: assert property ($rose(nand_we_n) && nand_cle &&
      nand_io_o == CMD_QUEUE_CONF |-> acnt == 3'h3 ##1 state == ST_WAIT)
      else $error("queued erase confirm wrong");
   plane_low_a: assert property (op == OP_ERASE_Q && state != ST_IDLE
      |-> !arow[PLANE_BIT])
      else $error("queued erase plane bit not low");
   same_plane_a: assert property (op == OP_CB_PROG && state != ST_IDLE
      |-> arow[PLANE_BIT] == src_plane)
      else $error("copy program left the source plane");
   queue_guard_a: assert property (state == ST_IDLE && go && q_pend &&
      !(nop inside {OP_ERASE, OP_ERASE_Q, OP_STATUS, OP_STAT_ENH,
      OP_RESET}) |=> err && state == ST_IDLE)
      else $error("command slipped into an erase queue");
   queue_ready_a: assert property (state == ST_IDLE && go && q_pend &&
      nop == OP_ERASE_Q && !(stat_byte[ST_BIT_RDY] &&
      stat_byte[ST_BIT_ARDY]) |=> state == ST_IDLE [*2])
      else $error("queued before ready status");
   rand_in_a: assert property (state == ST_IDLE && go &&
      nop == OP_RAND_IN && !cb_ok |=> err && state == ST_IDLE)
      else $error("data input without copy read");
   wait_rb_a: assert property (state == ST_WAIT && cnt == 3'h0 && rb_lvl
      |=> state != ST_WAIT)
      else $error("ready not honoured");

   copy_c: cover property ($rose(nand_we_n) && nand_cle &&
      nand_io_o == CMD_PROG_CONF);
   erase_c: cover property ($rose(nand_we_n) && nand_cle &&
      nand_io_o == CMD_ERASE_CONF && $past(q_pend, 24));
   queue_c: cover property ($rose(nand_we_n) && nand_cle &&
      nand_io_o == CMD_QUEUE_CONF);
   reset_c: cover property ($rose(nand_we_n) && nand_cle &&
      nand_io_o == CMD_RESET);
endmodule : nandcb_host
`default_nettype wire

/* File: nandcb_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nandcb_flash_model #(
   parameter int BUSY = 20
) (
   input wire logic clk,
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic wp_n,
   input wire logic [7:0] din,
   input wire logic fail_en,
   output logic [7:0] dout,
   output logic rb_n
);
   // ****************************************
   // behavioural flash device
   // ****************************************
   logic [7:0] cache [0:15];
   logic [7:0] cmd = 8'h00, last = 8'h00, rd;
   logic [23:0] row = 24'h0;
   logic [15:0] col = 16'h0;
   logic fail = 1'b0, smode = 1'b0, pwe = 1'b1, pre = 1'b1;
   logic [1:0] pl = 2'b00;
   int cnt = 0, na = 0, nlast = 0;
   assign rb_n = (cnt == 0);
   // status byte: protect, cache ready, array ready, pass/fail
   assign rd = smode ? {wp_n, rb_n, rb_n, 4'h0, fail}
      : cache[col[3:0]];
   // released bus shows the inverse so a stale byte never passes
   assign dout = (!re_n && !ce_n) ? rd : ~last;
   // strobes are host registers, so edges are seen one clock late
   always @(posedge clk) begin
      pwe <= we_n;
      pre <= re_n;
      if (cnt > 0) cnt <= cnt - 1;
      if (!pre && re_n && !ce_n) begin
         last <= rd;
         if (!smode) col <= col + 16'h1;
      end
      if (!pwe && we_n && !ce_n) begin
         if (ale) begin
            na <= na + 1;
            case ((cmd == 8'h60 || cmd == 8'h78) ? na + 2 : na)
               0: col[7:0] <= din;
               1: col[15:8] <= din;
               2: row[7:0] <= din;
               3: row[15:8] <= din;
               default: row[23:16] <= din;
            endcase
         end else if (cle && (cnt == 0 ||
                      din inside {8'h70, 8'h78, 8'hFF})) begin
            cmd <= din;
            na <= 0;
            smode <= (din == 8'h70 || din == 8'h78);
            case (din)
               8'h35: begin
                  cnt <= BUSY;
                  for (int i = 0; i < 16; i++) cache[i] <= row[7:0] ^ 8'(i);
               end
               8'h10: begin
                  cnt <= BUSY;
                  fail <= fail_en;
               end
               8'hD0, 8'hD1: begin
                  cnt <= BUSY;
                  fail <= fail_en;
                  nlast <= na;
                  pl <= {pl[0], row[6]};
               end
               8'hFF: begin
                  cnt <= BUSY;
                  fail <= 1'b0;
               end
               default: ;
            endcase
         end else if (!cle && cnt == 0) begin
            cache[col[3:0]] <= din;
            col <= col + 16'h1;
         end
      end
   end
endmodule : nandcb_flash_model
`default_nettype wire

/* File: tb_nandcb_host.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_nandcb_host import nandcb_pkg::*; ;
   logic ref_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, fail_en = 0;
   logic [7:0] adr = 8'h00, io_o, io_i, dev_io;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0, dat_o;
   logic ack, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb, saw = 0;
   int n_fail = 0, checks_done = 0;
   always #50 ref_clk = ~ref_clk;
   always @(negedge rb) saw <= 1'b1;
   assign io_i = io_oe ? io_o : dev_io;
   nandcb_host i_nandcb_host (.ref_clk(ref_clk), .rst_n(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
      .read_strobe_n(re_n), .nand_wp_n(wp_n), .nand_io_o(io_o),
      .nand_io_oe(io_oe), .nand_io_i(io_i), .ready_busy_n(rb));
   nandcb_flash_model i_nandcb_flash_model (.clk(ref_clk), .ce_n(ce_n),
      .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
      .din(io_i), .fail_en(fail_en), .dout(dev_io), .rb_n(rb));
   // ****************************************
   // shared bus and check tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // classic cycle; held until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int t;
      t = 0;
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      @(posedge ref_clk);
      while (ack !== 1'b1 && t < 50) begin
         @(posedge ref_clk);
         t++;
      end
      q = dat_o;
      if (t >= 50) chk("wb ack", 1, 0);
      {cyc, stb} <= 2'b00;
      @(posedge ref_clk);
   endtask : wb
   // start an operation and poll until the controller is idle
   task automatic run(input logic [3:0] op, input logic [23:0] r,
                      input logic [15:0] c, output logic [31:0] s);
      int t;
      t = 0;
      wb(1, A_COL, {16'h0, c}, s);
      wb(1, A_ROW, {8'h0, r}, s);
      wb(1, A_CTRL, {28'h0, op}, s);
      do begin
         wb(0, A_STAT, 0, s);
         t++;
      end while (s[16] === 1'b1 && t < 400);
      chk("busy after op", 0, s[16]);
   endtask : run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_idle;
      logic [31:0] s;
      wb(0, A_STAT, 0, s);
      chk("stat after reset", 0, s);
      wb(0, 8'h40, 0, s);
      chk("unmapped read", 0, s);
      chk("wp after reset", 0, wp_n);
      $display("test idle done");
   endtask : t_idle
   task automatic t_reset;
      logic [31:0] s;
      saw = 0;
      run(4'h7, 0, 0, s);
      chk("reset status wp low", 8'h60, s[15:8]);
      chk("reset busy seen", 1, saw);
      wb(1, A_CFG, 1, s);
      run(4'h7, 0, 0, s);
      chk("reset status wp high", 8'hE0, s[15:8]);
      wb(1, A_CFG, 0, s);
      run(4'h8, 0, 0, s);
      chk("status wp low", 8'h60, s[15:8]);
      wb(1, A_CFG, 1, s);
      $display("test reset done");
   endtask : t_reset
   task automatic t_copy;
      logic [31:0] s;
      run(4'h0, 24'h000123, 16'h0003, s);
      run(4'h4, 0, 0, s);
      chk("copy byte col 3", 8'h20, s[7:0]);
      run(4'h4, 0, 0, s);
      chk("copy byte col 4", 8'h27, s[7:0]);
      run(4'h3, 0, 16'h000A, s);
      chk("random out col 10", 8'h29, s[7:0]);
      wb(1, A_WDAT, 32'hA5, s);
      run(4'h2, 0, 16'h0005, s);
      chk("patched cache", 8'hA5, i_nandcb_flash_model.cache[5]);
      run(4'h1, 24'h000101, 0, s);
      chk("copy program status", 8'hE0, s[15:8]);
      chk("cache kept", 8'hA5, i_nandcb_flash_model.cache[5]);
      run(4'h2, 0, 16'h0005, s);
      chk("data input refused", 1, s[17]);
      fail_en <= 1'b1;
      run(4'h0, 24'h000123, 16'h0003, s);
      run(4'h1, 24'h000101, 0, s);
      chk("copy program fail", 8'hE1, s[15:8]);
      fail_en <= 1'b0;
      $display("test copy done");
   endtask : t_copy
   task automatic t_erase;
      logic [31:0] s;
      fail_en <= 1'b1;
      run(4'h5, 24'h000880, 0, s);
      chk("erase fail status", 8'hE1, s[15:8]);
      chk("erase addr cycles", 3, i_nandcb_flash_model.nlast);
      run(4'h9, 24'h000880, 0, s);
      chk("enhanced status", 8'hE1, s[15:8]);
      fail_en <= 1'b0;
      run(4'h6, 24'h000C40, 0, s);
      chk("queue status", 8'hE0, s[15:8]);
      run(4'h0, 24'h000123, 0, s);
      chk("copy read in queue", 1, s[17]);
      run(4'h5, 24'h000C00, 0, s);
      chk("final erase status", 8'hE0, s[15:8]);
      chk("plane order", 2'b01, i_nandcb_flash_model.pl);
      run(4'hF, 0, 0, s);
      chk("refused op", 1, s[17]);
      $display("test erase done");
   endtask : t_erase
   initial begin
      #(100 * 40000);
      n_fail++;
      report_and_stop;
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_idle;
      t_reset;
      t_copy;
      t_erase;
      report_and_stop;
   end
endmodule : tb_nandcb_host
`default_nettype wire
